// *** common/rcc_consts.vh ***
// Constants for the record-check block
`ifndef RCC_CONSTS_VH
`define RCC_CONSTS_VH
`define RCC_CHAR_W 7
`define RCC_DASH 7'h40
`define RCC_CR 7'h5b
`define RCC_LRC_RST 7'h00
`endif

// *** src/rcc_record_check.v ***
// Record-check logic: character parity and block longitudinal check
`include "rcc_consts.vh"
module rcc_record_check #(
  parameter W = `RCC_CHAR_W
) (
  // Clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // Options and keys (pins, synchronised)
  input wire auto_end_en_i,
  input wire block_end_key_i,
  input wire restart_key_i,
  // Transmit side: characters from keyboard
  input wire tx_valid_i,
  input wire [W-1:0] tx_char_i,
  output reg tx_valid_o,
  output reg [W-1:0] tx_char_o,
  output reg tx_is_check_o,
  // Receive side: characters from line
  input wire rx_valid_i,
  input wire [W:0] rx_char_i,
  input wire rx_is_check_i,
  output reg prt_valid_o,
  output reg [W-1:0] prt_char_o,
  output reg vrc_err_o,
  output reg lrc_err_o,
  output reg restart_lamp_o,
  output reg kbd_lock_o
);
  // Key and option synchronisers
  reg [1:0] bend_s_q;
  reg [1:0] rst_s_q;
  reg [1:0] auto_s_q;
  reg bend_prev_q;
  reg rst_prev_q;
  // Sender state
  reg [W-1:0] tx_lrc_q;
  reg [W-1:0] tx_lrc_d;
  reg bend_pend_q;
  reg bend_pend_d;
  reg tx_valid_d;
  reg [W-1:0] tx_char_d;
  reg tx_is_check_d;
  // Receiver state
  reg [W-1:0] rx_lrc_q;
  reg [W-1:0] rx_lrc_d;
  reg prt_valid_d;
  reg [W-1:0] prt_char_d;
  reg vrc_err_d;
  reg lrc_err_d;
  reg restart_lamp_d;
  reg kbd_lock_d;
  // Decoded events
  wire bend_rise;
  wire rst_rise;
  wire tx_cr;
  wire rx_data;
  wire rx_check;

  // Odd parity over data and parity bit
  function odd_ok;
    input [W:0] c;
    begin
      odd_ok = ^c;
    end
  endfunction

  // One step of the longitudinal check
  function [W-1:0] lrc_next;
    input [W-1:0] acc;
    input [W-1:0] c;
    begin
      lrc_next = acc ^ c;
    end
  endfunction

  assign bend_rise = bend_s_q[1] & ~bend_prev_q;
  assign rst_rise = rst_s_q[1] & ~rst_prev_q;
  assign tx_cr = tx_valid_i & (tx_char_i == `RCC_CR) & auto_s_q[1];
  assign rx_data = rx_valid_i & ~rx_is_check_i;
  assign rx_check = rx_valid_i & rx_is_check_i;

  // Block end key synchroniser and edge detector
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bend_s_q <= 2'h0;
      bend_prev_q <= 1'b0;
    end else begin
      bend_s_q <= {bend_s_q[0], block_end_key_i};
      bend_prev_q <= bend_s_q[1];
    end
  end

  // Restart key synchroniser and edge detector
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s_q <= 2'h0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_s_q <= {rst_s_q[0], restart_key_i};
      rst_prev_q <= rst_s_q[1];
    end
  end

  // Automatic block end option synchroniser
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      auto_s_q <= 2'h0;
    end else begin
      auto_s_q <= {auto_s_q[0], auto_end_en_i};
    end
  end

  // Sender: pass characters, then the check character at block end
  always @* begin
    tx_lrc_d = tx_lrc_q;
    bend_pend_d = bend_pend_q;
    tx_valid_d = 1'b0;
    tx_char_d = tx_char_o;
    tx_is_check_d = 1'b0;
    if (tx_valid_i) begin
      tx_valid_d = 1'b1;
      tx_char_d = tx_char_i;
      tx_lrc_d = lrc_next(tx_lrc_q, tx_char_i);
      // A block end during a character waits for the next idle cycle
      bend_pend_d = bend_pend_q | bend_rise | tx_cr;
    end else if (bend_pend_q | bend_rise) begin
      tx_valid_d = 1'b1;
      tx_char_d = tx_lrc_q;
      tx_is_check_d = 1'b1;
      tx_lrc_d = `RCC_LRC_RST;
      bend_pend_d = 1'b0;
    end
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_lrc_q <= `RCC_LRC_RST;
      bend_pend_q <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_char_o <= {W{1'b0}};
      tx_is_check_o <= 1'b0;
    end else begin
      tx_lrc_q <= tx_lrc_d;
      bend_pend_q <= bend_pend_d;
      tx_valid_o <= tx_valid_d;
      tx_char_o <= tx_char_d;
      tx_is_check_o <= tx_is_check_d;
    end
  end

  // Receiver: parity per character, block compare on check character
  always @* begin
    rx_lrc_d = rx_lrc_q;
    prt_valid_d = 1'b0;
    prt_char_d = prt_char_o;
    vrc_err_d = 1'b0;
    lrc_err_d = 1'b0;
    restart_lamp_d = restart_lamp_o;
    kbd_lock_d = kbd_lock_o;
    if (rst_rise) begin
      restart_lamp_d = 1'b0;
      kbd_lock_d = 1'b0;
    end
    if (rx_check) begin
      rx_lrc_d = `RCC_LRC_RST;
      if (rx_char_i[W-1:0] != rx_lrc_q) begin
        lrc_err_d = 1'b1;
        prt_valid_d = 1'b1;
        prt_char_d = `RCC_DASH;
        // Setting after the clear lets an error win over restart
        restart_lamp_d = 1'b1;
        kbd_lock_d = 1'b1;
      end
    end else if (rx_data) begin
      rx_lrc_d = lrc_next(rx_lrc_q, rx_char_i[W-1:0]);
      prt_valid_d = 1'b1;
      if (!odd_ok(rx_char_i)) begin
        vrc_err_d = 1'b1;
        prt_char_d = `RCC_DASH;
      end else begin
        prt_char_d = rx_char_i[W-1:0];
      end
    end
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_lrc_q <= `RCC_LRC_RST;
      prt_valid_o <= 1'b0;
      prt_char_o <= {W{1'b0}};
      vrc_err_o <= 1'b0;
      lrc_err_o <= 1'b0;
      restart_lamp_o <= 1'b0;
      kbd_lock_o <= 1'b0;
    end else begin
      rx_lrc_q <= rx_lrc_d;
      prt_valid_o <= prt_valid_d;
      prt_char_o <= prt_char_d;
      vrc_err_o <= vrc_err_d;
      lrc_err_o <= lrc_err_d;
      restart_lamp_o <= restart_lamp_d;
      kbd_lock_o <= kbd_lock_d;
    end
  end
endmodule

// *** sim/rcc_props.sv ***
// Checker for the record-check block
module rcc_props (
  input wire mclk_i, rstn_i, auto_end_en_i, block_end_key_i, restart_key_i,
  input wire tx_valid_i, tx_is_check_o, rx_valid_i, rx_is_check_i,
  input wire vrc_err_o, lrc_err_o, kbd_lock_o, restart_lamp_o,
  input wire [6:0] tx_char_i, tx_char_o, prt_char_o,
  input wire [7:0] rx_char_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire rxd = rx_valid_i && !rx_is_check_i;
  vrc_flag_a: assert property (rxd && !(^rx_char_i) |=> vrc_err_o) else $error("vrc");
  vrc_clean_a: assert property (rxd && ^rx_char_i |=> !vrc_err_o) else $error("vrc");
  lamp_on_a: assert property (lrc_err_o |-> restart_lamp_o) else $error("lamp");
  dash_out_a: assert property (rxd && !(^rx_char_i) |=> prt_char_o == 7'h40) else $error("dash");
  tx_echo_a: assert property (tx_valid_i |=> tx_char_o == $past(tx_char_i)) else $error("tx");
  key_send_a: assert property ($rose(block_end_key_i) |-> ##[1:8] tx_is_check_o) else $error("key");
  lrc_lock_a: assert property (lrc_err_o |-> ##[0:1] kbd_lock_o) else $error("lock");
  lock_hold_a: assert property (!restart_key_i [*4] ##0 kbd_lock_o |=> kbd_lock_o) else $error("hold");
  auto_end_a: assert property (tx_valid_i && tx_char_i == 7'h5b && auto_end_en_i
    |-> ##[1:8] tx_is_check_o) else $error("auto");
endmodule
bind rcc_record_check rcc_props chk (.*);

// *** sim/rcc_far.sv ***
// Far terminal model: returns each sent character with odd parity while f_i is low
module rcc_far (
  input wire clk_i, v_i, k_i, f_i,
  input wire [6:0] d_i,
  output reg rv_o = 0, rk_o = 0,
  output reg [7:0] rd_o = 0
);
  timeunit 1ns; timeprecision 1ns;
  // Idle line shows the inverse of the last value; f_i flips parity on data, bit 0 on check
  always @(negedge clk_i) begin
    rv_o <= v_i;
    rk_o <= v_i & k_i;
    rd_o <= v_i ? {~^d_i ^ (f_i & ~k_i), d_i ^ {6'h00, f_i & k_i}} : ~rd_o;
  end
endmodule

// *** sim/rcc_record_check_test.sv ***
// Self-checking bench for the record-check block
module rcc_record_check_test;
  timeunit 1ns; timeprecision 1ns;
  `define CK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t %h %h", $time, a, b); end end
  logic mclk_i = 0, rstn_i = 0, ae = 0, bk = 0, rs = 0, tv = 0, f = 0, rv, rk, vs, ls;
  logic [6:0] tc = 0, lc, lp;
  logic [7:0] rd;
  wire tvo, tko, pv, ve, le, lock, lamp;
  wire [6:0] tco, pc;
  int checked = 0, bad_count = 0, ck = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  rcc_record_check dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .auto_end_en_i(ae),
    .block_end_key_i(bk), .restart_key_i(rs), .tx_valid_i(tv), .tx_char_i(tc),
    .tx_valid_o(tvo), .tx_char_o(tco), .tx_is_check_o(tko), .rx_valid_i(rv),
    .rx_char_i(rd), .rx_is_check_i(rk), .prt_valid_o(pv), .prt_char_o(pc),
    .vrc_err_o(ve), .lrc_err_o(le), .restart_lamp_o(lamp), .kbd_lock_o(lock));
  rcc_far far (.clk_i(mclk_i), .v_i(tvo), .k_i(tko), .f_i(f), .d_i(tco),
    .rv_o(rv), .rk_o(rk), .rd_o(rd));
  always @(posedge mclk_i) begin
    if (tvo && tko) begin lc <= tco; ck <= ck + 1; end
    if (pv) lp <= pc;
    vs <= vs | ve; ls <= ls | le;
    if (++cyc > 3000) begin bad_count++; test_done; end
  end
  task put(input logic [6:0] c);
    @(negedge mclk_i) tv = 1; tc = c;
    @(negedge mclk_i) tv = 0;
    repeat (3) @(negedge mclk_i);
  endtask
  task press(input bit e);
    @(negedge mclk_i) if (e) bk = 1; else rs = 1;
    repeat (8) @(negedge mclk_i); bk = 0; rs = 0;
    repeat (8) @(negedge mclk_i);
  endtask
  task blk(input int n, input bit bad, fl, au);
    logic [6:0] a, c;
    int k;
    a = 0; k = ck; vs = 0; ls = 0; ae = au;
    for (int i = 0; i < n; i++) begin
      c = 7'($urandom) & 7'h3f;
      f = bad && i == 1; put(c); f = 0; a ^= c;
      `CK(lp, (bad && i == 1) ? 7'h40 : c)
    end
    f = fl;
    if (au) put(7'h5b); else press(1);
    repeat (8) @(negedge mclk_i); f = 0;
    `CK(ck, k + 1)
    if (!au) `CK(lc, a)
    `CK(ls, fl)
    `CK(vs, bad)
    `CK(lock, fl)
    `CK(lamp, fl)
    press(0);
    `CK(lock, 1'b0)
    `CK(lamp, 1'b0)
  endtask
  task test_done;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hfc58));
    repeat (10) @(negedge mclk_i); rstn_i = 1;
    blk(5, 1, 0, 0); blk(3, 0, 1, 0); blk(4, 0, 0, 1);
    test_done;
  end
endmodule
